/* verilog/abtw_ctrl.sv */
// Control block for burst power-up, tracking settings and window detection of a 12-bit converter.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module abtw_ctrl (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_start,
  output logic conv_go,
  input wire logic result_valid,
  input wire logic [11:0] result_data,
  output logic converter_powered,
  output logic [1:0] track_mode_select,
  output logic [1:0] post_track_time_select
);
  import abtw_pkg::*;

  // Register map seen over the bus, one byte register per aligned word.
  // Control: bit 7 enable, bit 6 burst, bit 3 window match flag, other bits plain storage.
  // Timing: bits 7:4 power-up count, bits 3:2 track mode, bits 1:0 post-track time.
  // Limits: greater-than and less-than values, each kept as a high byte and a low byte.
  // Result: the last result, zero-extended to 16 bits, split in a high and a low byte.
  // Status: bit 0 powered, bit 1 sleeping, bit 2 waking, bit 3 on.
  // Result and status ignore writes.
  // Any other address answers with an error, ignores writes and reads as zero.
  //
  // Power states of the sequencer.
  // Off: burst and enable both clear, so the core stays unpowered.
  // Sleep: burst set and enable clear, so the core rests until a start event arrives.
  // Wake: the power-up interval runs, and the start is released to the core when it ends.
  // On: enable set, so starts pass straight through one cycle later.
  // Except in wake, every state change lags the control write by one cycle.
  // Software therefore sees the new state on the status register two cycles after its write.
  //
  // Hazards and limits that a user must know.
  // A start that arrives while waking is dropped, because only one start can be pending.
  // The power-up counter is sized for the longest interval, sixteen steps of the step time.
  // Track mode and post-track time only reach the core; this block does not time tracking.
  // The window match flag is sticky until software writes it to zero.
  // A matching result wins over a clear in the same cycle, so no match is ever lost.
  // Equal limits take the outside branch, which makes every result but the limit a match.
  // The result is zero-extended before the compare, so the top four limit bits act as a guard.
  //
  // Bus timing.
  // Every transfer is a setup cycle and one access cycle, with no wait states.
  // Read data and the error answer are latched at the setup edge and stand in the access cycle.
  // A write lands at the access edge, the same edge at which the master samples ready.
  // The trade-off is that a read sees register contents one cycle older than the access edge.

  // Software-visible registers.
  logic [7:0] converter_control_reg;
  logic [7:0] burst_and_tracking_timing;
  logic [7:0] greater_than_limit_high;
  logic [7:0] greater_than_limit_low;
  logic [7:0] less_than_limit_high;
  logic [7:0] less_than_limit_low;
  logic [15:0] result_word;
  // Next values of the software-visible registers and the bus answer.
  logic [7:0] next_control;
  logic [7:0] next_timing;
  logic [7:0] next_gth;
  logic [7:0] next_gtl;
  logic [7:0] next_lth;
  logic [7:0] next_ltl;
  logic [15:0] next_result;
  logic [31:0] next_prdata;
  logic next_pslverr;
  // Power sequencer state, its power-up counter and the go pulse.
  abtw_pwr_t pwr_state;
  abtw_pwr_t next_pwr_state;
  logic [PWR_CNT_W-1:0] pwr_cnt;
  logic [PWR_CNT_W-1:0] next_pwr_cnt;
  logic next_conv_go;
  // Decoded bus strobes and the fields taken from the registers.
  logic wr_en;
  logic rd_en;
  logic converter_enable;
  logic burst_mode_enable;
  logic [3:0] burst_powerup_count;
  logic [15:0] gt_limit;
  logic [15:0] lt_limit;
  logic [15:0] sample;
  logic window_hit;
  logic addr_ok;

  // The slave answers in the first access cycle, so every transfer is two cycles long.
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  assign converter_enable = converter_control_reg[CTL_ENABLE_BIT];
  assign burst_mode_enable = converter_control_reg[CTL_BURST_BIT];
  assign burst_powerup_count = burst_and_tracking_timing[TK_PWR_LSB +: 4];
  assign track_mode_select = burst_and_tracking_timing[TK_TM_LSB +: 2];
  assign post_track_time_select = burst_and_tracking_timing[TK_PT_LSB +: 2];
  assign gt_limit = {greater_than_limit_high, greater_than_limit_low};
  assign lt_limit = {less_than_limit_high, less_than_limit_low};
  assign sample = {4'h0, result_data};

  // The window sense comes from limit order alone; no mode bit exists.
  always_comb begin
    if (lt_limit > gt_limit) begin
      window_hit = (sample > gt_limit) && (sample < lt_limit);
    end else begin
      window_hit = (sample < lt_limit) || (sample > gt_limit);
    end
  end

  // Address decode for both directions; unmapped addresses answer with an error.
  always_comb begin
    addr_ok = 1'b1;
    next_prdata = prdata;
    if (paddr == ADDR_CONTROL) begin
      next_prdata = {24'h0, converter_control_reg};
    end else if (paddr == ADDR_TIMING) begin
      next_prdata = {24'h0, burst_and_tracking_timing};
    end else if (paddr == ADDR_GT_HIGH) begin
      next_prdata = {24'h0, greater_than_limit_high};
    end else if (paddr == ADDR_GT_LOW) begin
      next_prdata = {24'h0, greater_than_limit_low};
    end else if (paddr == ADDR_LT_HIGH) begin
      next_prdata = {24'h0, less_than_limit_high};
    end else if (paddr == ADDR_LT_LOW) begin
      next_prdata = {24'h0, less_than_limit_low};
    end else if (paddr == ADDR_RESULT_HIGH) begin
      next_prdata = {24'h0, result_word[15:8]};
    end else if (paddr == ADDR_RESULT_LOW) begin
      next_prdata = {24'h0, result_word[7:0]};
    end else if (paddr == ADDR_STATUS) begin
      next_prdata = {28'h0, pwr_state == ABTW_ON, pwr_state == ABTW_WAKE, pwr_state == ABTW_SLEEP,
                     converter_powered};
    end else begin
      addr_ok = 1'b0;
      next_prdata = 32'h0;
    end
    if (!rd_en) begin
      next_prdata = prdata;
    end
    next_pslverr = psel & ~penable & ~addr_ok;
  end

  // Register writes; a window match in the same cycle as a clear still sets the flag.
  always_comb begin
    next_control = converter_control_reg;
    next_timing = burst_and_tracking_timing;
    next_gth = greater_than_limit_high;
    next_gtl = greater_than_limit_low;
    next_lth = less_than_limit_high;
    next_ltl = less_than_limit_low;
    next_result = result_word;
    if (wr_en) begin
      if (paddr == ADDR_CONTROL) begin
        next_control = pwdata[7:0];
      end else if (paddr == ADDR_TIMING) begin
        next_timing = pwdata[7:0];
      end else if (paddr == ADDR_GT_HIGH) begin
        next_gth = pwdata[7:0];
      end else if (paddr == ADDR_GT_LOW) begin
        next_gtl = pwdata[7:0];
      end else if (paddr == ADDR_LT_HIGH) begin
        next_lth = pwdata[7:0];
      end else if (paddr == ADDR_LT_LOW) begin
        next_ltl = pwdata[7:0];
      end
    end
    if (result_valid) begin
      next_result = sample;
      if (window_hit) begin
        next_control[CTL_WINDOW_BIT] = 1'b1;
      end
    end
  end

  // Power sequencing: a wake-up counts (count+1) steps of the step time before releasing the start.
  always_comb begin
    next_pwr_state = pwr_state;
    next_pwr_cnt = pwr_cnt;
    next_conv_go = 1'b0;
    case (pwr_state)
      // Unpowered; the first control write that sets enable or burst picks the next state.
      ABTW_OFF: begin
        if (converter_enable) begin
          next_pwr_state = ABTW_ON;
        end else if (burst_mode_enable) begin
          next_pwr_state = ABTW_SLEEP;
        end
      end
      // Resting in burst mode; a start event begins the power-up interval.
      ABTW_SLEEP: begin
        if (!burst_mode_enable) begin
          next_pwr_state = converter_enable ? ABTW_ON : ABTW_OFF;
        end else if (converter_enable) begin
          next_pwr_state = ABTW_ON;
        end else if (conv_start) begin
          next_pwr_state = ABTW_WAKE;
          next_pwr_cnt = PWR_CNT_W'(({6'h0, burst_powerup_count} + 10'h1) * PWR_STEP_CYCLES_W);
        end
      end
      // Counting down the power-up interval; starts seen here are dropped.
      ABTW_WAKE: begin
        if (pwr_cnt <= PWR_CNT_W'(1)) begin
          next_conv_go = 1'b1;
          next_pwr_state = ABTW_SLEEP;
          next_pwr_cnt = '0;
        end else begin
          next_pwr_cnt = pwr_cnt - PWR_CNT_W'(1);
        end
      end
      // Powered continuously; each start is passed on one cycle later.
      ABTW_ON: begin
        next_conv_go = conv_start;
        if (!converter_enable) begin
          next_pwr_state = burst_mode_enable ? ABTW_SLEEP : ABTW_OFF;
        end
      end
      default: begin
        next_pwr_state = ABTW_OFF;
      end
    endcase
  end

  // Powered while on or waking; sleep and off keep the core unpowered.
  assign converter_powered = (pwr_state == ABTW_ON) || (pwr_state == ABTW_WAKE);

  // Software-visible registers and the captured result.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      converter_control_reg <= CONTROL_RESET;
      burst_and_tracking_timing <= TIMING_RESET;
      greater_than_limit_high <= LIMIT_BYTE_RESET;
      greater_than_limit_low <= LIMIT_BYTE_RESET;
      less_than_limit_high <= LIMIT_BYTE_RESET;
      less_than_limit_low <= LIMIT_BYTE_RESET;
      result_word <= 16'h0;
    end else begin
      converter_control_reg <= next_control;
      burst_and_tracking_timing <= next_timing;
      greater_than_limit_high <= next_gth;
      greater_than_limit_low <= next_gtl;
      less_than_limit_high <= next_lth;
      less_than_limit_low <= next_ltl;
      result_word <= next_result;
    end
  end

  // Bus answer registers; read data stands until the next read.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Power sequencer state, counter and go pulse.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pwr_state <= ABTW_OFF;
      pwr_cnt <= '0;
      conv_go <= 1'b0;
    end else begin
      pwr_state <= next_pwr_state;
      pwr_cnt <= next_pwr_cnt;
      conv_go <= next_conv_go;
    end
  end
endmodule // abtw_ctrl
`default_nettype wire

/* verilog/abtw_pkg.sv */
// Package of register map, field layout and timing constants for the burst, tracking and window block.
package abtw_pkg;
  // APB byte addresses of the word registers.
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h04;
  localparam logic [7:0] ADDR_GT_HIGH = 8'h08;
  localparam logic [7:0] ADDR_GT_LOW = 8'h0c;
  localparam logic [7:0] ADDR_LT_HIGH = 8'h10;
  localparam logic [7:0] ADDR_LT_LOW = 8'h14;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h18;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  // Control register bit positions.
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_BURST_BIT = 6;
  localparam int CTL_WINDOW_BIT = 3;
  // Timing register field positions.
  localparam int TK_PWR_LSB = 4;
  localparam int TK_TM_LSB = 2;
  localparam int TK_PT_LSB = 0;
  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] TIMING_RESET = 8'hff;
  localparam logic [7:0] LIMIT_BYTE_RESET = 8'h00;
  // Track mode codes.
  localparam logic [1:0] TM_RESERVED = 2'h0;
  localparam logic [1:0] TM_POST = 2'h1;
  localparam logic [1:0] TM_PRE = 2'h2;
  localparam logic [1:0] TM_DUAL = 2'h3;
  // Burst power-up step time and its cycle count at the system clock.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PWR_STEP_NS = 200;
  localparam int PWR_STEP_CYCLES = (PWR_STEP_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [9:0] PWR_STEP_CYCLES_W = 10'(PWR_STEP_CYCLES);
  // Width of the power-up counter: up to 16 steps of the step time.
  localparam int PWR_CNT_W = 10;
  // Power control states.
  typedef enum logic [1:0] {
    ABTW_OFF,
    ABTW_SLEEP,
    ABTW_WAKE,
    ABTW_ON
  } abtw_pwr_t;
endpackage : abtw_pkg

/* dv/abtw_monitor.sv */
// Checker of port timing for the burst, tracking and window control block.
`timescale 1ns/100ps
`default_nettype none
module abtw_monitor
  import abtw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic conv_start,
  input wire logic conv_go,
  input wire logic converter_powered,
  input wire logic [1:0] track_mode_select,
  input wire logic [1:0] post_track_time_select
);
  logic [1:0] ctl;
  logic [1:0] next_ctl;
  // Mirror of enable and burst, taken at the same edge as the design takes a control write.
  always_comb begin
    next_ctl = ctl;
    if (!rstn) next_ctl = 2'h0;
    else if (psel && penable && pwrite && paddr == ADDR_CONTROL) next_ctl = pwdata[7:6];
  end
  // Registers the mirror.
  always_ff @(posedge clk_sys) begin
    ctl <= next_ctl;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  slv_unmapped_a: assert property (psel && !penable && paddr > ADDR_STATUS |=> pslverr)
    else $error("unmapped access without error");
  timing_fields_a: assert property (psel && penable && pwrite && paddr == ADDR_TIMING |=>
    {track_mode_select, post_track_time_select} == $past(pwdata[3:0])) else $error("timing fields wrong");
  burst_off_a: assert property (!ctl[0] && ctl == $past(ctl) |-> converter_powered == ctl[1])
    else $error("power does not follow enable");
  always_on_a: assert property (ctl == 2'h3 && $past(ctl) == 2'h3 |-> converter_powered)
    else $error("power dropped in burst on");
  go_follow_a: assert property (ctl == 2'h3 && $past(ctl) == 2'h3 && conv_start |=> conv_go)
    else $error("go missing in burst on");
  sleep_hold_a: assert property (ctl == 2'h1 && $past(ctl) == 2'h1 && !converter_powered && !conv_start
    |=> !converter_powered) else $error("woke without start");
  wake_hold_a: assert property (ctl == 2'h1 && $past(ctl) == 2'h1 && conv_start && !converter_powered
    |=> !conv_go [*8]) else $error("go before power-up time");
  go_single_a: assert property (ctl == 2'h1 && conv_go |=> !conv_go)
    else $error("go longer than one cycle");
endmodule // abtw_monitor
`default_nettype wire

/* dv/abtw_core_model.sv */
// Behavioural model of the converter core that answers a go pulse with a result.
`timescale 1ns/100ps
`default_nettype none
module abtw_core_model #(
  parameter int DLY = 3
) (
  input wire logic clk_sys,
  input wire logic conv_go,
  input wire logic [11:0] sample,
  output logic result_valid,
  output logic [11:0] result_data
);
  logic [DLY-1:0] pipe = '0;
  initial result_valid = 1'b0;
  initial result_data = 12'h000;
  // Data toggles outside the valid pulse, so a stale result can never pass for a fresh one.
  always @(posedge clk_sys) begin
    pipe <= {pipe[DLY-2:0], conv_go};
    result_valid <= pipe[DLY-1];
    result_data <= pipe[DLY-1] ? sample : ~result_data;
  end
endmodule // abtw_core_model
`default_nettype wire

/* dv/abtw_ctrl_tb.sv */
// Self-checking testbench of the burst, tracking and window control block.
`timescale 1ns/100ps
`default_nettype none
module abtw_ctrl_tb;
  import abtw_pkg::*;
  logic clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, conv_start = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, conv_go, result_valid, converter_powered;
  logic [11:0] result_data, sample = 12'h000;
  logic [1:0] track_mode_select, post_track_time_select;
  int err_total = 0, n_tests = 0, cyc = 0, d;
  // Each entry: greater-than limit, less-than limit, result, expected flag.
  localparam logic [36:0] WIN [8] = '{{12'h100, 12'h200, 12'h180, 1'b1}, {12'h100, 12'h200, 12'h100, 1'b0},
    {12'h100, 12'h200, 12'h200, 1'b0}, {12'h200, 12'h100, 12'h0ff, 1'b1}, {12'h200, 12'h100, 12'h201, 1'b1},
    {12'h200, 12'h100, 12'h150, 1'b0}, {12'h200, 12'h100, 12'h200, 1'b0}, {12'h7ff, 12'hfff, 12'hffe, 1'b1}};
  abtw_ctrl abtw_ctrl_i (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .conv_start, .conv_go, .result_valid, .result_data, .converter_powered, .track_mode_select,
    .post_track_time_select);
  abtw_core_model abtw_core_model_i (.clk_sys, .conv_go, .sample, .result_valid, .result_data);
  // Free-running system clock.
  initial forever #2.5 clk_sys = ~clk_sys;
  task summarize();
    $display("mismatches %0d, checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the edge that samples pready.
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, dat};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task pulse();
    @(posedge clk_sys);
    conv_start <= 1'b1;
    @(posedge clk_sys);
    conv_start <= 1'b0;
  endtask
  // Hang guard; the tests need well under a thousand cycles.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    xfer(0, ADDR_TIMING, 0);
    chk(rd, 32'hff);
    chk(32'({track_mode_select, post_track_time_select}), 32'hf);
    xfer(0, 8'h24, 0);
    chk({rd[30:0], er}, 32'h1);
    for (int m = 0; m < 4; m++) begin
      xfer(1, ADDR_TIMING, 8'(m * 5));
      @(negedge clk_sys);
      chk(32'({track_mode_select, post_track_time_select}), 32'(m * 5));
    end
    xfer(1, ADDR_CONTROL, 8'h80);
    repeat (2) @(posedge clk_sys);
    chk(32'(converter_powered), 32'h1);
    xfer(0, ADDR_STATUS, 0);
    chk(rd, 32'h9);
    xfer(1, ADDR_CONTROL, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk(32'(converter_powered), 32'h0);
    // Sleep and wake with the shortest and a longer power-up count.
    for (int k = 0; k < 4; k += 3) begin
      xfer(1, ADDR_TIMING, 8'(k * 16 + 15));
      xfer(1, ADDR_CONTROL, 8'h40);
      repeat (2) @(posedge clk_sys);
      chk(32'(converter_powered), 32'h0);
      pulse();
      d = 0;
      while (conv_go !== 1'b1 && d < 1000) begin
        @(posedge clk_sys);
        d++;
      end
      chk(32'(d >= (k + 1) * PWR_STEP_CYCLES && d <= (k + 1) * PWR_STEP_CYCLES + 1), 32'h1);
      repeat (3) @(posedge clk_sys);
      chk(32'(converter_powered), 32'h0);
    end
    // Window cases, run with the converter held on.
    foreach (WIN[i]) begin
      xfer(1, ADDR_GT_HIGH, {4'h0, WIN[i][36:33]});
      xfer(1, ADDR_GT_LOW, WIN[i][32:25]);
      xfer(1, ADDR_LT_HIGH, {4'h0, WIN[i][24:21]});
      xfer(1, ADDR_LT_LOW, WIN[i][20:13]);
      xfer(0, ADDR_LT_LOW, 0);
      chk(rd, {24'h0, WIN[i][20:13]});
      sample <= WIN[i][12:1];
      xfer(1, ADDR_CONTROL, 8'hc0);
      pulse();
      @(posedge clk_sys);
      chk(32'(conv_go), 32'h1);
      d = 0;
      while (result_valid !== 1'b1 && d < 20) begin
        @(posedge clk_sys);
        d++;
      end
      xfer(0, ADDR_CONTROL, 0);
      chk(32'(rd[CTL_WINDOW_BIT]), 32'(WIN[i][0]));
      xfer(0, ADDR_RESULT_LOW, 0);
      chk(rd, {24'h0, WIN[i][8:1]});
    end
    summarize();
  end
endmodule // abtw_ctrl_tb
bind abtw_ctrl abtw_monitor abtw_monitor_i (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
  .conv_start, .conv_go, .converter_powered, .track_mode_select, .post_track_time_select);
`default_nettype wire
